// >>> rtl/ppirq_defines.svh
// Purpose: offsets, field positions, reset values and timing counts of the port mode block
// Assumes: included by bare name from design files
// Notes: definitions only
`ifndef PPIRQ_DEFINES_SVH
`define PPIRQ_DEFINES_SVH
// ============================================================
// register offsets
`define PPIRQ_OFF_MODE 4'h0
`define PPIRQ_OFF_STAT 4'h1
// ============================================================
// mode register fields
`define PPIRQ_BUSY_BIT 15
`define PPIRQ_IRQ_HI 14
`define PPIRQ_IRQ_LO 13
`define PPIRQ_STEP_HI 12
`define PPIRQ_STEP_LO 11
`define PPIRQ_WIDE_BIT 10
`define PPIRQ_PMODE_HI 9
`define PPIRQ_PMODE_LO 8
`define PPIRQ_SWAIT_HI 7
`define PPIRQ_SWAIT_LO 6
`define PPIRQ_MODE_RESET 16'h0000
`define PPIRQ_MODE_WMASK 16'h7FFF
// ============================================================
// timing: instruction cycle in clock cycles, base setup wait in instruction cycles
`define PPIRQ_TCY_CLKS 8'h02
`define PPIRQ_SETUP_BASE 3'h1
`endif

// >>> rtl/ppirq_pkg.sv
// Purpose: shared types of the port mode block
// Assumes: nothing
// Notes: codes as held in the mode register
package ppirq_pkg;
   typedef enum logic [1:0] {
      PPIRQ_IRQ_NONE = 2'h0,
      PPIRQ_IRQ_END = 2'h1,
      PPIRQ_IRQ_STALL = 2'h2,
      PPIRQ_IRQ_BUF3 = 2'h3
   } ppirq_irq_t;
   typedef enum logic [1:0] {
      PPIRQ_PM_LEGACY = 2'h0,
      PPIRQ_PM_ENH = 2'h1,
      PPIRQ_PM_MAST2 = 2'h2,
      PPIRQ_PM_MAST1 = 2'h3
   } ppirq_pmode_t;
   typedef enum logic [1:0] {
      PPIRQ_ST_HOLD = 2'h0,
      PPIRQ_ST_INC = 2'h1,
      PPIRQ_ST_DEC = 2'h2,
      PPIRQ_ST_BUF = 2'h3
   } ppirq_step_t;
endpackage : ppirq_pkg

// >>> rtl/ppirq_cfg_if.sv
// Purpose: carries decoded mode fields from the register file to the sequencer
// Assumes: one clock domain
// Notes: plain wires
`timescale 1ns/1ps
interface ppirq_cfg_if;
   import ppirq_pkg::*;
   ppirq_irq_t irq_sel;
   ppirq_pmode_t pmode;
   ppirq_step_t step;
   logic [1:0] setup_wait;
   logic start;
   logic busy;
   logic done;
   modport ctrl (output irq_sel, output pmode, output step, output setup_wait, output start,
      input busy, input done);
   modport seq (input irq_sel, input pmode, input step, input setup_wait, input start,
      output busy, output done);
endinterface : ppirq_cfg_if

// >>> rtl/ppirq_seq.sv
// Purpose: times one master transfer as setup wait then one strobe instruction cycle
// Assumes: start is a one-cycle pulse, ignored while busy
// Notes: setup wait of code n lasts n+1 instruction cycles
`timescale 1ns/1ps
`include "ppirq_defines.svh"
module ppirq_seq
   import ppirq_pkg::*;
(
   input wire logic clk_in,
   input wire logic rst_in,
   ppirq_cfg_if.seq cfg
);
   typedef enum logic [2:0] {
      PPIRQ_S_IDLE = 3'b001,
      PPIRQ_S_SETUP = 3'b010,
      PPIRQ_S_STROBE = 3'b100
   } ppirq_seq_st_t;
   typedef struct packed {
      ppirq_seq_st_t st;
      logic [7:0] tick;
      logic [2:0] left;
      logic done;
   } ppirq_seq_t;
   ppirq_seq_t s_q, s_d;
   logic tcy_end;

   // ============================================================
   // sequencer
   assign tcy_end = (s_q.tick == `PPIRQ_TCY_CLKS - 8'h01);
   assign cfg.busy = (s_q.st != PPIRQ_S_IDLE);
   assign cfg.done = s_q.done;

   always_comb begin
      s_d = s_q;
      s_d.done = 1'b0;
      s_d.tick = tcy_end ? 8'h00 : s_q.tick + 8'h01;
      case (s_q.st)
         PPIRQ_S_IDLE: begin
            s_d.tick = 8'h00;
            if (cfg.start) begin
               s_d.left = {1'b0, cfg.setup_wait} + `PPIRQ_SETUP_BASE;
               s_d.st = PPIRQ_S_SETUP;
            end
         end
         PPIRQ_S_SETUP: begin
            if (tcy_end) begin
               s_d.left = s_q.left - 3'h1;
               if (s_q.left == 3'h1) begin
                  s_d.st = PPIRQ_S_STROBE;
               end
            end
         end
         PPIRQ_S_STROBE: begin
            if (tcy_end) begin
               s_d.st = PPIRQ_S_IDLE;
               s_d.done = 1'b1;
            end
         end
         default: begin
            s_d.st = PPIRQ_S_IDLE;
         end
      endcase
   end

   always_ff @(posedge clk_in) begin
      if (rst_in) begin
         s_q <= '{st: PPIRQ_S_IDLE, tick: 8'h00, left: 3'h0, done: 1'b0};
      end else begin
         s_q <= s_d;
      end
   end
endmodule : ppirq_seq

// >>> rtl/ppirq_ctrl.sv
// Purpose: mode register and interrupt request control of the parallel port
// Assumes: register port and slave strobes are synchronous to clk_in
// Notes: strobe engine and data path live elsewhere; this block times and flags
//
// How it works
// - mode 11 in buffered slave operation flags when read buffer 3 or write buffer 3 is touched.
// - mode 11 in addressable slave operation flags on an access at port address 11.
// - mode 10 flags nothing and stalls the processor until the transfer ends.
// - mode 01 flags at the end of each read or write cycle.
// - mode 00, the reset value, flags nothing.
// - the port mode field picks master 1, master 2, enhanced slave or legacy slave.
// - the step field increments, decrements or holds the 11-bit address, or walks buffers.
// - with the wide bit clear each data access is one 8-bit transfer.
// - the setup wait field sets the setup wait, code n lasting n+1 instruction cycles.
//
// Local design decisions: the address map and the strobed register port.
`timescale 1ns/1ps
`include "ppirq_defines.svh"
module ppirq_ctrl
   import ppirq_pkg::*;
#(
   parameter int ADDR_W = 11
) (
   input wire logic clk_in,
   input wire logic rst_in,
   input wire logic [3:0] reg_addr_in,
   input wire logic [15:0] reg_wdata_in,
   input wire logic reg_wr_in,
   input wire logic reg_rd_in,
   output logic [15:0] reg_rdata_out,
   input wire logic data_access_in,
   input wire logic slave_rd_in,
   input wire logic slave_wr_in,
   input wire logic [1:0] port_addr_lines_in,
   output logic irq_out,
   output logic stall_out,
   output logic master_strobe_out,
   output logic [ADDR_W-1:0] port_addr_out,
   output logic [1:0] buf_idx_out,
   output logic [1:0] port_type_out
);
   typedef struct packed {
      logic [15:0] mode;
      logic [15:0] rdata;
      logic irq;
      logic stall;
      logic strobe;
      logic [ADDR_W-1:0] addr;
      logic [1:0] rbuf;
      logic [1:0] wbuf;
      logic [1:0] ptype;
      logic [7:0] done_cnt;
   } ppirq_ctrl_t;
   ppirq_ctrl_t r_q, r_d;
   ppirq_cfg_if cfg ();
   logic master_mode;
   logic slave_acc;
   logic buf3_hit;

   // helper: is this port mode a master type
   function automatic logic is_master(input logic [1:0] pm);
      is_master = (pm == PPIRQ_PM_MAST1) || (pm == PPIRQ_PM_MAST2);
   endfunction : is_master

   // ============================================================
   // field decode
   assign cfg.irq_sel = ppirq_irq_t'(r_q.mode[`PPIRQ_IRQ_HI:`PPIRQ_IRQ_LO]);
   assign cfg.pmode = ppirq_pmode_t'(r_q.mode[`PPIRQ_PMODE_HI:`PPIRQ_PMODE_LO]);
   assign cfg.step = ppirq_step_t'(r_q.mode[`PPIRQ_STEP_HI:`PPIRQ_STEP_LO]);
   assign cfg.setup_wait = r_q.mode[`PPIRQ_SWAIT_HI:`PPIRQ_SWAIT_LO];
   assign master_mode = is_master(r_q.mode[`PPIRQ_PMODE_HI:`PPIRQ_PMODE_LO]);
   // narrow mode: one transfer per data access; wide mode also starts one here
   assign cfg.start = data_access_in && master_mode && !cfg.busy;
   assign slave_acc = !master_mode && (slave_rd_in || slave_wr_in);

   // buffered slave hit on buffer 3
   // addressable slave hit on address 11
   always_comb begin
      buf3_hit = 1'b0;
      if (cfg.pmode == PPIRQ_PM_LEGACY) begin
         buf3_hit = (slave_rd_in && r_q.rbuf == 2'h3) || (slave_wr_in && r_q.wbuf == 2'h3);
      end else if (cfg.pmode == PPIRQ_PM_ENH) begin
         buf3_hit = slave_acc && (port_addr_lines_in == 2'h3);
      end
   end

   ppirq_seq u_seq (
      .clk_in(clk_in),
      .rst_in(rst_in),
      .cfg(cfg)
   );

   // ============================================================
   // register file and request logic
   always_comb begin
      r_d = r_q;
      r_d.irq = 1'b0;
      r_d.rdata = 16'h0000;
      r_d.strobe = cfg.busy;
      r_d.ptype = cfg.pmode;
      if (reg_wr_in && reg_addr_in == `PPIRQ_OFF_MODE) begin
         r_d.mode = reg_wdata_in & `PPIRQ_MODE_WMASK;
      end
      if (reg_rd_in) begin
         case (reg_addr_in)
            `PPIRQ_OFF_MODE: begin
               r_d.rdata = r_q.mode;
               r_d.rdata[`PPIRQ_BUSY_BIT] = master_mode && cfg.busy;
            end
            `PPIRQ_OFF_STAT: begin
               r_d.rdata = {r_q.done_cnt, 2'h0, r_q.wbuf, r_q.rbuf, r_q.stall, cfg.busy};
            end
            default: begin
               r_d.rdata = 16'h0000;
            end
         endcase
      end
      case (cfg.irq_sel)
         PPIRQ_IRQ_END: begin
            r_d.irq = cfg.done || (!master_mode && (slave_rd_in || slave_wr_in));
         end
         PPIRQ_IRQ_STALL: begin
            r_d.stall = cfg.start || (cfg.busy && !cfg.done);
         end
         PPIRQ_IRQ_BUF3: begin
            r_d.irq = buf3_hit;
         end
         default: begin
            r_d.irq = 1'b0;
         end
      endcase
      if (cfg.irq_sel != PPIRQ_IRQ_STALL) begin
         r_d.stall = 1'b0;
      end
      if (cfg.done) begin
         r_d.done_cnt = r_q.done_cnt + 8'h01;
         case (cfg.step)
            PPIRQ_ST_INC: begin
               r_d.addr = r_q.addr + ADDR_W'(1);
            end
            PPIRQ_ST_DEC: begin
               r_d.addr = r_q.addr - ADDR_W'(1);
            end
            default: begin
               r_d.addr = r_q.addr;
            end
         endcase
      end
      if (cfg.step == PPIRQ_ST_BUF && cfg.pmode == PPIRQ_PM_LEGACY) begin
         if (slave_rd_in) begin
            r_d.rbuf = r_q.rbuf + 2'h1;
         end
         if (slave_wr_in) begin
            r_d.wbuf = r_q.wbuf + 2'h1;
         end
      end
   end

   always_ff @(posedge clk_in) begin
      if (rst_in) begin
         r_q <= '0;
         r_q.mode <= `PPIRQ_MODE_RESET;
      end else begin
         r_q <= r_d;
      end
   end

   // ============================================================
   // outputs straight from flops
   assign reg_rdata_out = r_q.rdata;
   assign irq_out = r_q.irq;
   assign stall_out = r_q.stall;
   assign master_strobe_out = r_q.strobe;
   assign port_addr_out = r_q.addr;
   assign buf_idx_out = r_q.rbuf;
   assign port_type_out = r_q.ptype;
endmodule : ppirq_ctrl

// >>> verif/ppirq_ctrl_monitor.sv
// Purpose: port checks of the mode and interrupt block
// Assumes: mode field shadowed from register writes
// Notes: bound to ppirq_ctrl
`timescale 1ns/1ps
module ppirq_ctrl_monitor (
   input wire logic clk_in,
   input wire logic rst_in,
   input wire logic [3:0] reg_addr_in,
   input wire logic [15:0] reg_wdata_in,
   input wire logic reg_wr_in,
   input wire logic reg_rd_in,
   input wire logic [15:0] reg_rdata_out,
   input wire logic data_access_in,
   input wire logic slave_rd_in,
   input wire logic slave_wr_in,
   input wire logic [1:0] port_addr_lines_in,
   input wire logic irq_out,
   input wire logic master_strobe_out,
   input wire logic [1:0] port_type_out
);
   logic [15:0] mode_q;
   logic acc;
   // shadow of the mode word; bit 15 never takes a write
   always_ff @(posedge clk_in) begin
      if (rst_in) mode_q <= 16'h0000;
      else if (reg_wr_in && reg_addr_in == 4'h0) mode_q <= reg_wdata_in & 16'h7FFF;
   end
   assign acc = slave_rd_in | slave_wr_in;
   default clocking @(posedge clk_in); endclocking
   default disable iff (rst_in);
   sequence slv_hit;
      acc && mode_q[9:8] == 2'h1 && port_addr_lines_in == 2'h3;
   endsequence
   sequence m_start;
      data_access_in && mode_q[9] && !master_strobe_out && !$past(data_access_in);
   endsequence
   // ============================================================
   // checks; the past guard skips a pulse from just before a mode change
   irq_off_quiet_a: assert property (
      mode_q[14:13] == 2'h0 && $past(mode_q[14:13]) == 2'h0 |-> !irq_out) else $error("irq in mode 0");
   stall_no_irq_a: assert property (
      mode_q[14:13] == 2'h2 && $past(mode_q[14:13]) == 2'h2 |-> !irq_out) else $error("irq in mode 2");
   end_irq_a: assert property (
      acc && mode_q[14:13] == 2'h1 && !mode_q[9] |=> irq_out) else $error("no end irq");
   addr3_irq_a: assert property (
      (mode_q[14:13] == 2'h3) ##0 slv_hit |=> irq_out) else $error("no addr 3 irq");
   addr_other_a: assert property (
      acc && mode_q[14:13] == 2'h3 && mode_q[9:8] == 2'h1 && port_addr_lines_in != 2'h3
      |=> !irq_out) else $error("irq off addr 3");
   mode_read_a: assert property (
      reg_rd_in && reg_addr_in == 4'h0 |=> reg_rdata_out[14:0] == $past(mode_q[14:0]))
      else $error("mode readback");
   port_type_a: assert property (
      (!reg_wr_in)[*2] |-> port_type_out == mode_q[9:8]) else $error("port type");
   busy_span_a: assert property (
      m_start |=> !master_strobe_out ##1 master_strobe_out[*4]) else $error("strobe span");
endmodule : ppirq_ctrl_monitor
bind ppirq_ctrl ppirq_ctrl_monitor i_mon (.clk_in, .rst_in, .reg_addr_in, .reg_wdata_in,
   .reg_wr_in, .reg_rd_in, .reg_rdata_out, .data_access_in, .slave_rd_in, .slave_wr_in,
   .port_addr_lines_in, .irq_out, .master_strobe_out, .port_type_out);

// >>> verif/ppirq_slave_model.sv
// Purpose: outside master touching the slave port
// Assumes: one-cycle strobes
// Notes: idle address lines show the inverse of the last value
`timescale 1ns/1ps
module ppirq_slave_model (
   input wire logic clk_in,
   output logic slave_rd_out,
   output logic slave_wr_out,
   output logic [1:0] port_addr_out
);
   initial begin
      slave_rd_out = 1'b0;
      slave_wr_out = 1'b0;
      port_addr_out = 2'h0;
   end
   // released address lines are inverted so a stale address never looks valid
   task automatic access(input logic [1:0] a, input logic wr);
      @(posedge clk_in);
      slave_rd_out <= !wr;
      slave_wr_out <= wr;
      port_addr_out <= a;
      @(posedge clk_in);
      slave_rd_out <= 1'b0;
      slave_wr_out <= 1'b0;
      port_addr_out <= ~a;
   endtask : access
endmodule : ppirq_slave_model

// >>> verif/parallel_port_irq_mode_ctrl_bench.sv
// Purpose: self-checking bench of the port mode block
// Assumes: an instruction cycle is two clocks; setup code n waits n+1 of them
// Notes: irq, strobe and stall cycles are counted
`timescale 1ns/1ps
module parallel_port_irq_mode_ctrl_bench;
   logic clk_in = 1'b0;
   logic rst_in = 1'b1;
   logic [3:0] addr = 4'h0;
   logic [15:0] wdata = 16'h0000;
   logic wr = 1'b0;
   logic rd = 1'b0;
   logic dacc = 1'b0;
   logic [15:0] rdata;
   logic srd, swr, irq, stall, strobe;
   logic [1:0] pa, bidx, ptype;
   logic [10:0] paddr;
   int n_mismatch = 0;
   int n_compared = 0;
   int n_irq = 0;
   int n_strb = 0;
   int n_stall = 0;
   int e_addr = 0;
   int e_done = 0;
   ppirq_ctrl i_dut (.clk_in, .rst_in, .reg_addr_in(addr), .reg_wdata_in(wdata), .reg_wr_in(wr),
      .reg_rd_in(rd), .reg_rdata_out(rdata), .data_access_in(dacc), .slave_rd_in(srd),
      .slave_wr_in(swr), .port_addr_lines_in(pa), .irq_out(irq), .stall_out(stall),
      .master_strobe_out(strobe), .port_addr_out(paddr), .buf_idx_out(bidx),
      .port_type_out(ptype));
   ppirq_slave_model i_part (.clk_in, .slave_rd_out(srd), .slave_wr_out(swr), .port_addr_out(pa));
   initial begin
      forever #2.5 clk_in = ~clk_in;
   end
   // ============================================================
   // event counters shared by all scenarios
   always @(posedge clk_in) begin
      if (irq === 1'b1) n_irq <= n_irq + 1;
      if (strobe === 1'b1) n_strb <= n_strb + 1;
      if (stall === 1'b1) n_stall <= n_stall + 1;
   end
   task automatic check(input logic [15:0] seen, input logic [15:0] exp);
      n_compared++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask : check
   task automatic reg_write(input logic [3:0] a, input logic [15:0] d);
      @(posedge clk_in);
      addr <= a;
      wdata <= d;
      wr <= 1'b1;
      @(posedge clk_in);
      wr <= 1'b0;
   endtask : reg_write
   task automatic reg_read(input logic [3:0] a, output logic [15:0] d);
      @(posedge clk_in);
      addr <= a;
      rd <= 1'b1;
      @(posedge clk_in);
      rd <= 1'b0;
      @(negedge clk_in);
      d = rdata;
   endtask : reg_read
   task automatic t_regs;
      logic [15:0] d;
      reg_read(4'h0, d);
      check(d, 16'h0000);
      reg_write(4'h0, 16'hFFFF);
      reg_read(4'h0, d);
      check(d, 16'h7FFF);
      reg_read(4'h5, d);
      check(d, 16'h0000);
      $display("end regs");
   endtask : t_regs
   task automatic t_irq_modes;
      int base;
      for (int m = 0; m < 4; m++) begin
         reg_write(4'h0, 16'h0100 | 16'(m << 13));
         base = n_irq;
         i_part.access(2'h3, 1'b0);
         repeat (3) @(posedge clk_in);
         check(16'(n_irq - base), 16'(m % 2));
         base = n_irq;
         i_part.access(2'h1, 1'b1);
         repeat (3) @(posedge clk_in);
         check(16'(n_irq - base), 16'(m == 1));
      end
      check(16'(ptype), 16'h0001);
      $display("end irq modes");
   endtask : t_irq_modes
   task automatic t_buf;
      int base;
      reg_write(4'h0, 16'h7800);
      base = n_irq;
      for (int i = 0; i < 8; i++) begin
         i_part.access(2'h0, i >= 4);
         repeat (2) @(posedge clk_in);
         check(16'(n_irq - base), 16'(i / 4 + (i % 4 == 3)));
         check(16'(bidx), 16'((i < 4) ? (i + 1) % 4 : 0));
      end
      $display("end buffers");
   endtask : t_buf
   task automatic t_master(input int m, input int st, input int w);
      logic [15:0] d;
      int b_irq, b_strb, b_stall;
      reg_write(4'h0, 16'(m << 13) | 16'(st << 11) | 16'(w << 6) | 16'h0300);
      b_irq = n_irq;
      b_strb = n_strb;
      b_stall = n_stall;
      @(posedge clk_in);
      dacc <= 1'b1;
      @(posedge clk_in);
      dacc <= 1'b0;
      reg_read(4'h0, d);
      if (m != 2) check(16'(d[15]), 16'h0001);
      repeat (16) @(posedge clk_in);
      e_addr = (st == 1) ? e_addr + 1 : (st == 2) ? e_addr - 1 : e_addr;
      e_done = e_done + 1;
      // setup of w+1 instruction cycles, then one strobe cycle, two clocks each
      check(16'(n_strb - b_strb), 16'(2 * (w + 1) + 2));
      check(16'(n_irq - b_irq), 16'(m == 1));
      check(16'(n_stall != b_stall), 16'(m == 2));
      check(16'(paddr), 16'(e_addr));
      check(16'(ptype), 16'h0003);
      // one data access gives exactly one transfer; port idle, buffers back at 0
      reg_read(4'h1, d);
      check(d, 16'(e_done << 8));
      $display("end master");
   endtask : t_master
   task automatic finish_test;
      $display("compared %0d mismatched %0d", n_compared, n_mismatch);
      if (n_mismatch == 0 && n_compared > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask : finish_test
   initial begin
      #20000;
      n_mismatch++;
      finish_test();
   end
   initial begin
      repeat (10) @(posedge clk_in);
      rst_in <= 1'b0;
      t_regs();
      t_irq_modes();
      t_buf();
      t_master(1, 1, 3);
      t_master(2, 2, 2);
      t_master(0, 0, 1);
      finish_test();
   end
endmodule : parallel_port_irq_mode_ctrl_bench
